// >>> design/sbe_consts.svh
// Register offsets, field positions, reset values and spacing counts of the
// burst engine controller. Definitions only; included by the controller and its bench.
`ifndef SBE_CONSTS_SVH
`define SBE_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SBE_REG_CTRL      8'h00
`define SBE_REG_CFG       8'h04
`define SBE_REG_ADDR      8'h08
`define SBE_REG_OPEN      8'h0C
`define SBE_REG_STAT      8'h10
`define SBE_REG_BUF       8'h20
`define SBE_REG_BUF_MASK  8'hE0

// ****************************************
// Field positions and reset values
// ****************************************
`define SBE_CTRL_ORD_LSB  0
`define SBE_CFG_BURST8    0
`define SBE_CFG_ILV       1
`define SBE_CFG_CAS_LSB   4
`define SBE_CFG_ADD_LSB   8
`define SBE_CAS_RESET     3'h3
`define SBE_ADD_RESET     3'h0
`define SBE_ADDR_AP       10
`define SBE_ADDR_BANK_LSB 12
`define SBE_STAT_BUSY     0
`define SBE_STAT_DONE     1
`define SBE_STAT_REFUSED  2
`define SBE_STAT_TMO      3

// ****************************************
// Mode register load fields
// ****************************************
`define SBE_MR_BURST4            3'h2
`define SBE_MR_BURST8            3'h3
`define SBE_BURST_TYPE_SELECT_BIT 3
`define SBE_MR_CAS_LSB           4
`define SBE_EMR_ADD_LSB          3
`define SBE_EMR_BANK             3'h1

// ****************************************
// Command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define SBE_CMD_DESEL 4'hF
`define SBE_CMD_READ  4'h5
`define SBE_CMD_WRITE 4'h4
`define SBE_CMD_MODE  4'h0
`define SBE_CMD_STOP  4'h6

// ****************************************
// Spacing in memory clocks, timeout slack in system clocks
// ****************************************
`define SBE_RTW_B4    4
`define SBE_RTW_B8    6
`define SBE_WRITE_TO_READ_TURNAROUND_CK   2
`define SBE_RD_SLACK  12'h020

`endif

// >>> design/sbe_pkg.sv
// Types shared by the burst engine controller, its DRAM model and its bench.
// Assumes sbe_consts.svh carries the numbers.
package sbe_pkg;

	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT, ST_HOLD, ST_WLAT, ST_WDATA, ST_POST, ST_RDATA
	} sbe_state_t;

	typedef enum logic [1:0] {
		ORD_READ, ORD_WRITE, ORD_MODE, ORD_EXT_MODE
	} sbe_order_t;

	typedef struct packed {
		logic [2:0] additive_latency;
		logic [2:0] column_strobe_latency;
		logic       interleave;
		logic       burst8;
	} sbe_cfg_t;

	// Command bits in order cs_n, ras_n, cas_n, we_n
	typedef struct packed {
		logic [3:0]  cmd;
		logic [2:0]  ba;
		logic [13:0] a;
	} sbe_cmd_pins_t;

endpackage

// >>> design/sbe_sync.sv
// Two-flop synchroniser for pins that arrive from the memory side.
// Assumes the input is a level; the first stage feeds only the second.
`timescale 1ns/10ps

module sbe_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  logic         clk,
	input  logic         rstn,
	// Pin in, synchronised out
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sbe_sync_state_t;

	sbe_sync_state_t s;
	sbe_sync_state_t n;

	if (W < 1) begin : g_bad_width
		$error("sbe_sync width must be at least one");
	end

	always_comb begin
		n.s1 = d;
		n.s2 = s.s1;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.s2;

endmodule

// >>> design/sbe_order.sv
// Column order of one beat inside a burst.
// Assumes beat stays below four when the burst length is four.
`timescale 1ns/10ps

module sbe_order (
	// Burst start and beat index
	input  logic [2:0] start_col,
	input  logic [2:0] beat,
	// Ordering type
	input  logic       interleave,
	// Low column bits of this beat
	output logic [2:0] beat_col
);
	always_comb begin
		if (interleave) begin
			beat_col = start_col ^ beat;
		end else begin
			// Wrap stays inside the nibble; upper half follows the other nibble
			beat_col = {start_col[2] ^ beat[2], start_col[1:0] + beat[1:0]};
		end
	end

endmodule

// >>> design/sbe_ctrl.sv
// Burst read/write controller that drives a double-data-rate DRAM by its pins.
// Assumes banks are opened by other logic, mirrored by software in the open
// register, and that configuration is not changed while an order runs.
`timescale 1ns/10ps
`include "sbe_consts.svh"

// Summary of operation
// - Address bit three selects burst ordering type
// - No burst stop command exists
// - Read is cs, cas low; ras, we high
// - Write is cs, cas, we low; ras high
// - Write latency is read latency minus one
// - Controller drives write preamble, beats per edge
// - Read to write spacing four or six
// - Write to read waits latency, half burst, turnaround
// - Seamless writes every half burst length
// - Seamless reads at burst dependent interval
// - Never interrupt a burst of four
// - Burst eight interrupted only same direction
// - Interruption exactly two clocks after previous
// - Auto-precharge bursts never interrupted
// - Spacing uses programmed burst length
// - Only access activated banks
// - Column commands at least two clocks apart
module sbe_ctrl
	import sbe_pkg::*;
#(
	parameter int DW      = 8,
	parameter int CK_DIV  = 4,
	parameter int WRITE_TO_READ_TURNAROUND_CK = `SBE_WRITE_TO_READ_TURNAROUND_CK
) (
	// Clock and reset
	input  logic                clk,
	input  logic                rstn,
	// Register port
	input  logic [7:0]          reg_addr,
	input  logic [31:0]         reg_wdata,
	input  logic                reg_wr,
	input  logic                reg_rd,
	output logic [31:0]         reg_rdata,
	// Memory clock and command
	output logic                mem_ck,
	output logic                mem_ck_n,
	output sbe_cmd_pins_t       mem_cmd,
	// Data, strobe and mask
	output logic [DW-1:0]       dq_o,
	output logic                dq_oe,
	input  logic [DW-1:0]       dq_i,
	output logic                dqs_o,
	output logic                dqs_oe,
	input  logic                dqs_i,
	output logic [DW/8-1:0]     write_byte_mask
);
	localparam int MW = DW / 8;
	localparam int EW = DW + MW;
	localparam logic [3:0]  D_M1 = 4'(CK_DIV - 1);
	localparam logic [4:0]  PH_D = 5'(CK_DIV - 1);
	localparam logic [4:0]  PH_H = 5'(CK_DIV / 2 - 1);
	localparam logic [11:0] D_C  = 12'(CK_DIV);
	localparam logic [11:0] H_C  = 12'(CK_DIV / 2);
	localparam logic [11:0] P_C  = 12'(2 * CK_DIV);

	if (DW % 8 != 0 || DW < 8 || EW > 32 || CK_DIV < 2 || CK_DIV > 16 ||
		CK_DIV % 2 != 0) begin : g_bad_param
		$error("sbe_ctrl parameters out of range");
	end

	typedef struct packed {
		sbe_state_t          st;
		sbe_order_t          ord;
		sbe_cfg_t            cfg;
		logic [9:0]          col;
		logic                ap;
		logic [2:0]          bank;
		logic [7:0]          open;
		logic                busy;
		logic                done;
		logic                refused;
		logic                tmo;
		logic                last_rd;
		logic                last_wr;
		logic [11:0]         tcnt;
		logic [5:0]          gap;
		logic [2:0]          beat;
		logic [4:0]          ph;
		logic [3:0]          div;
		logic                ck;
		logic                ck_n;
		sbe_cmd_pins_t       pins;
		logic [DW-1:0]       dq;
		logic                dq_oe;
		logic                dqs;
		logic                dqs_oe;
		logic [MW-1:0]       wmask;
		logic                dqs_prev;
		logic [7:0][EW-1:0]  buffer;
		logic [31:0]         rdata;
	} sbe_top_state_t;

	sbe_top_state_t s;
	sbe_top_state_t n;
	logic [DW-1:0]  sync_dq;
	logic           sync_dqs;
	logic [2:0]     beat_sel;
	logic [2:0]     beat_col;
	logic [3:0]     wr_lat;
	logic [11:0]    w_t;
	logic [11:0]    pre_t;
	logic [11:0]    d0_t;
	logic [11:0]    to_t;
	logic [5:0]     half;
	logic [5:0]     need;
	logic [2:0]     last_beat;

	// ****************************************
	// Pin synchronisers and burst order
	// ****************************************
	sbe_sync #(.W(DW + 1)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({dqs_i, dq_i}),
		.q    ({sync_dqs, sync_dq})
	);

	assign beat_sel = (s.st == ST_WDATA) ? s.beat + 3'h1 : s.beat;

	sbe_order u_order (
		.start_col  (s.col[2:0]),
		.beat       (beat_sel),
		.interleave (s.cfg.interleave),
		.beat_col   (beat_col)
	);

	// ****************************************
	// Latency and spacing figures
	// ****************************************
	always_comb begin
		wr_lat = 4'({1'b0, s.cfg.additive_latency}) +
			4'({1'b0, s.cfg.column_strobe_latency}) - 4'h1;
		w_t = 12'(wr_lat) * P_C;
		pre_t = D_C + w_t - P_C;
		d0_t = D_C + w_t - H_C;
		// Read window: read latency is one clock beyond write latency
		to_t = D_C + w_t + P_C * 12'h6 + `SBE_RD_SLACK;
		half = s.cfg.burst8 ? 6'h4 : 6'h2;
		last_beat = s.cfg.burst8 ? 3'h7 : 3'h3;
		if (s.last_rd && s.ord == ORD_WRITE) begin
			need = s.cfg.burst8 ? 6'(`SBE_RTW_B8) : 6'(`SBE_RTW_B4);
		end else if (s.last_wr && s.ord == ORD_READ) begin
			need = 6'({3'h0, s.cfg.column_strobe_latency}) - 6'h1 + half +
				6'(WRITE_TO_READ_TURNAROUND_CK);
		end else begin
			need = half;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		sbe_order_t req;
		logic       column;
		logic       ck_fall;
		logic       ck_rise;
		req = ORD_READ;
		column = 1'b0;
		ck_fall = 1'b0;
		ck_rise = 1'b0;
		n = s;
		n.rdata = '0;
		n.dqs_prev = sync_dqs;

		// Memory clock is made here, so it is no second domain
		if (s.div == D_M1) begin
			n.div = '0;
			n.ck = ~s.ck;
			n.ck_n = s.ck;
			ck_fall = s.ck;
			ck_rise = ~s.ck;
		end else begin
			n.div = s.div + 4'h1;
		end
		if (ck_rise && s.gap != 6'h3F) begin
			n.gap = s.gap + 6'h1;
		end
		if (s.st != ST_IDLE && s.st != ST_WAIT) begin
			n.tcnt = s.tcnt + 12'h1;
		end
		// A command stands one whole memory clock around its rising edge
		if (s.tcnt == P_C - 12'h1) begin
			n.pins = '{cmd: `SBE_CMD_DESEL, ba: 3'h0, a: 14'h0};
		end

		if (reg_wr) begin
			case (reg_addr)
				`SBE_REG_CFG: begin
					n.cfg.additive_latency = reg_wdata[`SBE_CFG_ADD_LSB +: 3];
					n.cfg.column_strobe_latency = reg_wdata[`SBE_CFG_CAS_LSB +: 3];
					n.cfg.interleave = reg_wdata[`SBE_CFG_ILV];
					n.cfg.burst8 = reg_wdata[`SBE_CFG_BURST8];
				end
				`SBE_REG_ADDR: begin
					n.col = reg_wdata[9:0];
					n.ap = reg_wdata[`SBE_ADDR_AP];
					n.bank = reg_wdata[`SBE_ADDR_BANK_LSB +: 3];
				end
				`SBE_REG_OPEN: n.open = reg_wdata[7:0];
				`SBE_REG_STAT: begin
					n.done = s.done & ~reg_wdata[`SBE_STAT_DONE];
					n.refused = s.refused & ~reg_wdata[`SBE_STAT_REFUSED];
					n.tmo = s.tmo & ~reg_wdata[`SBE_STAT_TMO];
				end
				`SBE_REG_CTRL: begin
					req = sbe_order_t'(reg_wdata[`SBE_CTRL_ORD_LSB +: 2]);
					column = (req == ORD_READ) || (req == ORD_WRITE);
					if (s.st != ST_IDLE || (column && !s.open[s.bank])) begin
						n.refused = 1'b1;
					end else begin
						n.st = ST_WAIT;
						n.ord = req;
						n.busy = 1'b1;
						n.done = 1'b0;
					end
				end
				default: begin
					if ((reg_addr & `SBE_REG_BUF_MASK) == `SBE_REG_BUF &&
						reg_addr[1:0] == 2'h0) begin
						n.buffer[reg_addr[4:2]] = reg_wdata[EW-1:0];
					end
				end
			endcase
		end

		if (reg_rd) begin
			case (reg_addr)
				`SBE_REG_CTRL: n.rdata = {30'h0, s.ord};
				`SBE_REG_CFG: begin
					n.rdata[`SBE_CFG_ADD_LSB +: 3] = s.cfg.additive_latency;
					n.rdata[`SBE_CFG_CAS_LSB +: 3] = s.cfg.column_strobe_latency;
					n.rdata[`SBE_CFG_ILV] = s.cfg.interleave;
					n.rdata[`SBE_CFG_BURST8] = s.cfg.burst8;
				end
				`SBE_REG_ADDR: n.rdata = {17'h0, s.bank, 1'b0, s.ap, s.col};
				`SBE_REG_OPEN: n.rdata = {24'h0, s.open};
				`SBE_REG_STAT: n.rdata = {28'h0, s.tmo, s.refused, s.done, s.busy};
				default: begin
					if ((reg_addr & `SBE_REG_BUF_MASK) == `SBE_REG_BUF &&
						reg_addr[1:0] == 2'h0) begin
						n.rdata = 32'(s.buffer[reg_addr[4:2]]);
					end
				end
			endcase
		end

		// Each order finishes its burst before the next may start, so a burst
		// is never cut short and auto-precharge is always safe
		unique case (s.st)
			ST_IDLE: begin
			end
			ST_WAIT: begin
				if (ck_fall && s.gap >= need) begin
					n.tcnt = '0;
					n.beat = 3'h0;
					n.pins = '{cmd: `SBE_CMD_MODE, ba: 3'h0, a: 14'h0};
					unique case (s.ord)
						ORD_READ: begin
							n.pins = '{cmd: `SBE_CMD_READ, ba: s.bank,
								a: {3'h0, s.ap, s.col}};
							n.st = ST_RDATA;
						end
						ORD_WRITE: begin
							n.pins = '{cmd: `SBE_CMD_WRITE, ba: s.bank,
								a: {3'h0, s.ap, s.col}};
							n.st = ST_WLAT;
						end
						ORD_MODE: begin
							n.pins.a[2:0] = s.cfg.burst8 ? `SBE_MR_BURST8 : `SBE_MR_BURST4;
							n.pins.a[`SBE_BURST_TYPE_SELECT_BIT] = s.cfg.interleave;
							n.pins.a[`SBE_MR_CAS_LSB +: 3] = s.cfg.column_strobe_latency;
							n.st = ST_HOLD;
						end
						ORD_EXT_MODE: begin
							n.pins.ba = `SBE_EMR_BANK;
							n.pins.a[`SBE_EMR_ADD_LSB +: 3] = s.cfg.additive_latency;
							n.st = ST_HOLD;
						end
					endcase
					if (s.ord == ORD_READ || s.ord == ORD_WRITE) begin
						n.gap = '0;
						n.last_rd = (s.ord == ORD_READ);
						n.last_wr = (s.ord == ORD_WRITE);
					end
				end
			end
			ST_HOLD: begin
				if (s.tcnt == P_C - 12'h1) begin
					n.st = ST_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
			ST_WLAT: begin
				if (s.tcnt == pre_t - 12'h1) begin
					n.dqs_oe = 1'b1;
					n.dqs = 1'b0;
				end
				if (s.tcnt == d0_t - 12'h1) begin
					// Data leads each strobe edge by a quarter clock
					n.dq = s.buffer[beat_col][DW-1:0];
					n.wmask = s.buffer[beat_col][DW +: MW];
					n.dq_oe = 1'b1;
					n.ph = '0;
					n.st = ST_WDATA;
				end
			end
			ST_WDATA: begin
				n.ph = s.ph + 5'h1;
				if (s.ph == PH_H) begin
					n.dqs = ~s.dqs;
				end
				if (s.ph == PH_D) begin
					n.ph = '0;
					if (s.beat == last_beat) begin
						n.dq_oe = 1'b0;
						n.wmask = '0;
						n.st = ST_POST;
					end else begin
						n.beat = s.beat + 3'h1;
						n.dq = s.buffer[beat_col][DW-1:0];
						n.wmask = s.buffer[beat_col][DW +: MW];
					end
				end
			end
			ST_POST: begin
				n.ph = s.ph + 5'h1;
				if (s.ph == PH_H) begin
					n.dqs_oe = 1'b0;
					n.st = ST_IDLE;
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
			ST_RDATA: begin
				n.wmask = '0;
				// Preamble holds the strobe low, so the first rise is beat 0
				if ((sync_dqs != s.dqs_prev) && (s.beat != 3'h0 || sync_dqs)) begin
					n.buffer[beat_col][DW-1:0] = sync_dq;
					if (s.beat == last_beat) begin
						n.st = ST_IDLE;
						n.busy = 1'b0;
						n.done = 1'b1;
					end else begin
						n.beat = s.beat + 3'h1;
					end
				end else if (s.tcnt == to_t) begin
					n.tmo = 1'b1;
					n.st = ST_IDLE;
					n.busy = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.cfg.column_strobe_latency <= `SBE_CAS_RESET;
			s.cfg.additive_latency <= `SBE_ADD_RESET;
			s.pins.cmd <= `SBE_CMD_DESEL;
			s.gap <= 6'h3F;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;
	assign mem_ck = s.ck;
	assign mem_ck_n = s.ck_n;
	assign mem_cmd = s.pins;
	assign dq_o = s.dq;
	assign dq_oe = s.dq_oe;
	assign dqs_o = s.dqs;
	assign dqs_oe = s.dqs_oe;
	assign write_byte_mask = s.wmask;

	// ****************************************
	// Checks
	// ****************************************
	logic [3:0] edge_cnt;
	logic       dqs_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			edge_cnt <= '0;
			dqs_q <= 1'b0;
		end else begin
			dqs_q <= s.dqs;
			if (!s.dqs_oe) begin
				edge_cnt <= '0;
			end else if (s.dqs != dqs_q) begin
				edge_cnt <= edge_cnt + 4'h1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_read_pins;
		(s.pins.cmd == `SBE_CMD_READ) [*2];
	endsequence
	sequence s_write_pins;
		(s.pins.cmd == `SBE_CMD_WRITE) [*2];
	endsequence
	sequence s_preamble;
		!s.dqs [*2];
	endsequence

	a_read_encode: assert property ((s.st == ST_WAIT) && (n.st == ST_RDATA) |=> s_read_pins)
		else $error("read command pins wrong");
	a_write_encode: assert property ((s.st == ST_WAIT) && (n.st == ST_WLAT) |=> s_write_pins)
		else $error("write command pins wrong");
	a_no_stop: assert property (s.pins.cmd != `SBE_CMD_STOP)
		else $error("burst stop pattern driven");
	a_write_latency: assert property ((s.st == ST_WDATA) && (s.beat == 3'h0) && $rose(s.dqs)
		|-> (s.tcnt == D_C + w_t) && $rose(s.ck))
		else $error("first write strobe edge off the latency point");
	a_write_preamble: assert property ($rose(s.dqs_oe) |-> s_preamble)
		else $error("write preamble not low");
	a_write_beats: assert property ($fell(s.dqs_oe) |-> edge_cnt == (s.cfg.burst8 ? 4'h8 : 4'h4))
		else $error("write strobe edge count differs from burst length");
	a_read_mask: assert property ($past(s.st) == ST_RDATA |-> s.wmask == '0)
		else $error("mask driven during read");
	a_burst_length: assert property ((s.pins.cmd == `SBE_CMD_MODE) && (s.pins.ba == 3'h0)
		|-> s.pins.a[2:0] == (s.cfg.burst8 ? `SBE_MR_BURST8 : `SBE_MR_BURST4))
		else $error("mode load burst length code wrong");
	a_burst_type: assert property ((s.pins.cmd == `SBE_CMD_MODE) && (s.pins.ba == 3'h0)
		|-> s.pins.a[`SBE_BURST_TYPE_SELECT_BIT] == s.cfg.interleave)
		else $error("mode load burst type bit wrong");
	a_col_spacing: assert property ((s.st == ST_WAIT) && (n.st inside {ST_RDATA, ST_WLAT})
		|-> s.gap >= need && s.gap >= 6'h2)
		else $error("column command spacing too short");
	a_open_bank: assert property ((s.st == ST_WAIT) && (n.st inside {ST_RDATA, ST_WLAT})
		|-> s.open[s.bank])
		else $error("column command to idle bank");

endmodule

// >>> verif/sbe_mem_model.sv
// Behavioural DRAM at the far side of the burst engine controller.
// Assumes CK_DIV=4 at 100 MHz, so one memory clock lasts 80 ns.
`timescale 1ns/10ps

module sbe_mem_model
	import sbe_pkg::*;
#(
	parameter real T_MEM = 80.0
) (
	// Command side
	input  logic          mem_ck,
	input  sbe_cmd_pins_t mem_cmd,
	// Write direction
	input  logic [7:0]    dq_o,
	input  logic          dq_oe,
	input  logic          dqs_o,
	input  logic          dqs_oe,
	input  logic [0:0]    write_byte_mask,
	// Read direction
	output logic [7:0]    dq_i,
	output logic          dqs_i,
	// Test control and rule breaches seen
	input  logic          mute,
	output int            viol
);
	logic [7:0] mem [8];
	logic       burst8;
	logic       ilv;
	logic [2:0] cas;
	logic [2:0] add;
	logic [2:0] wcol;
	int         nck;
	int         last_rd;
	int         last_wr;
	int         wbeat;
	realtime    t_wr;

	function automatic logic [2:0] col_of(logic [2:0] s, logic [2:0] k);
		return ilv ? s ^ k : {s[2] ^ k[2], s[1:0] + k[1:0]};
	endfunction

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		{burst8, ilv, cas, add} = {2'b00, 3'h3, 3'h0};
		nck = 0;
		last_rd = -100;
		last_wr = -100;
		wbeat = 8;
		viol = 0;
		dq_i = 8'h5A;
		dqs_i = 1'b0;
	end

	always @(posedge mem_ck) begin
		nck++;
		case (mem_cmd.cmd)
		4'h0: if (mem_cmd.ba == 3'h0) begin
			if (mem_cmd.a[2:1] != 2'b01) viol++;
			burst8 = mem_cmd.a[0];
			ilv = mem_cmd.a[3];
			cas = mem_cmd.a[6:4];
		end else add = mem_cmd.a[5:3];
		4'h6: viol++;
		4'h4: begin
			if (nck - last_rd < (burst8 ? 6 : 4)) viol++;
			if (nck - last_wr < (burst8 ? 4 : 2)) viol++;
			last_wr = nck;
			wcol = mem_cmd.a[2:0];
			wbeat = 0;
			t_wr = $realtime;
		end
		4'h5: begin
			if (nck - last_wr < cas + (burst8 ? 5 : 3)) viol++;
			if (nck - last_rd < (burst8 ? 4 : 2)) viol++;
			last_rd = nck;
			if (!mute) fork read_burst(mem_cmd.a[2:0]); join_none
		end
		default: ;
		endcase
	end

	// Only the programmed number of beats is taken; later strobes are ignored
	always @(dqs_o) begin
		if (dqs_oe && wbeat < (burst8 ? 8 : 4)) begin
			if (wbeat == 0 && (!dqs_o || !dq_oe)) viol++;
			if (wbeat == 0 && $realtime - t_wr != T_MEM * (add + cas - 1)) viol++;
			if (!write_byte_mask[0]) mem[col_of(wcol, wbeat[2:0])] = dq_o;
			wbeat++;
		end
	end

	task automatic read_burst(logic [2:0] s);
		repeat (int'(add) + int'(cas) - 1) @(posedge mem_ck);
		dqs_i <= 1'b0;
		@(posedge mem_ck);
		for (int k = 0; k < (burst8 ? 8 : 4); k++) begin
			if (k > 0) @(mem_ck);
			if (write_byte_mask !== 1'b0) viol++;
			dq_i  <= mem[col_of(s, 3'(k))];
			dqs_i <= ~k[0];
		end
		@(mem_ck);
		dq_i <= ~dq_i;
	endtask
endmodule

// >>> verif/test_sbe_ctrl.sv
// Self-checking bench for the burst engine controller and its DRAM model.
// Assumes default parameters: DW=8, CK_DIV=4, WRITE_TO_READ_TURNAROUND_CK=2.
`timescale 1ns/10ps
`include "sbe_consts.svh"

module test_sbe_ctrl
	import sbe_pkg::*;
;
	logic          clk;
	logic          rstn;
	logic          reg_wr;
	logic          reg_rd;
	logic [7:0]    reg_addr;
	logic [31:0]   reg_wdata;
	logic [31:0]   reg_rdata;
	logic [31:0]   rd_val;
	logic          mem_ck;
	logic          mem_ck_n;
	sbe_cmd_pins_t mem_cmd;
	logic [7:0]    dq_o;
	logic [7:0]    dq_i;
	logic          dq_oe;
	logic          dqs_o;
	logic          dqs_oe;
	logic          dqs_i;
	logic [0:0]    write_byte_mask;
	logic          mute;
	logic [7:0]    exp_mem [8];
	int            viol;
	int            failures;
	int            comparisons;

	sbe_ctrl DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_ck(mem_ck),
		.mem_ck_n(mem_ck_n), .mem_cmd(mem_cmd), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
		.dqs_o(dqs_o), .dqs_oe(dqs_oe), .dqs_i(dqs_i), .write_byte_mask(write_byte_mask));

	sbe_mem_model mdl (.mem_ck(mem_ck), .mem_cmd(mem_cmd), .dq_o(dq_o), .dq_oe(dq_oe),
		.dqs_o(dqs_o), .dqs_oe(dqs_oe), .write_byte_mask(write_byte_mask), .dq_i(dq_i),
		.dqs_i(dqs_i), .mute(mute), .viol(viol));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic check(string what, logic [31:0] seen, logic [31:0] expct);
		comparisons++;
		if (seen !== expct) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, expct, seen);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	// Start an order, poll until done or timeout, leave status in rd_val
	task automatic order(logic [1:0] o);
		int n;
		wr(`SBE_REG_CTRL, {30'h0, o});
		n = 0;
		do begin
			rd(`SBE_REG_STAT);
			n++;
		end while (rd_val[`SBE_STAT_DONE] !== 1'b1 && rd_val[`SBE_STAT_TMO] !== 1'b1 && n < 400);
		if (n >= 400) check("order wait", 32'h0, 32'h1);
	endtask

	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// One configuration: mode loads, write burst, read burst
	// ****************************************
	task automatic run_cfg(int k);
		logic [2:0] col;
		logic [7:0] d;
		logic       m;
		col = k[1] ? 3'h5 : 3'h1;
		wr(`SBE_REG_CFG, 32'(k[1] * 257 + k[0] * 2 + (3 + k[0]) * 16));
		order(2'd2);
		wr(`SBE_REG_STAT, 32'hE);
		order(2'd3);
		wr(`SBE_REG_STAT, 32'hE);
		for (int i = 0; i < 8; i++) begin
			d = 8'(17 * (k + 1) + i);
			m = (i == 3) && k[0];
			wr(8'(`SBE_REG_BUF + 4 * i), {23'h0, m, d});
			if (!m && (k[1] || i[2] == col[2])) exp_mem[i] = d;
		end
		// Odd configurations also carry the auto-precharge bit
		wr(`SBE_REG_ADDR, {17'h0, 3'(k), 1'b0, k[0], 7'h0, col});
		rd(`SBE_REG_ADDR);
		check("addr", rd_val, {17'h0, 3'(k), 1'b0, k[0], 7'h0, col});
		order(2'd1);
		check("write stat", rd_val & 32'hF, 32'h2);
		wr(`SBE_REG_STAT, 32'hE);
		for (int i = 0; i < 8; i++) check("stored", mdl.mem[i], exp_mem[i]);
		for (int i = 0; i < 8; i++) wr(8'(`SBE_REG_BUF + 4 * i), 32'hFF);
		wr(`SBE_REG_ADDR, {17'h0, 3'(k), 2'b0, 7'h0, col ^ 3'h2});
		order(2'd0);
		check("read stat", rd_val & 32'hF, 32'h2);
		wr(`SBE_REG_STAT, 32'hE);
		for (int i = 0; i < 8; i++) begin
			rd(8'(`SBE_REG_BUF + 4 * i));
			if (k[1] || i[2] == col[2])
				check("read data", rd_val[7:0], exp_mem[i]);
		end
	endtask

	initial begin
		{rstn, reg_wr, reg_rd, mute} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		foreach (exp_mem[i]) exp_mem[i] = 8'h00;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(`SBE_REG_CFG);
		check("cfg reset", rd_val, 32'h30);
		rd(`SBE_REG_STAT);
		check("stat reset", rd_val, 32'h0);
		rd(8'h40);
		check("unmapped", rd_val, 32'h0);
		check("ck pair", {31'h0, mem_ck_n}, {31'h0, ~mem_ck});
		// Bank two is not yet marked open, so no command may leave
		wr(`SBE_REG_ADDR, 32'h2000);
		wr(`SBE_REG_CTRL, 32'h1);
		rd(`SBE_REG_STAT);
		check("refused", rd_val, 32'h4);
		wr(`SBE_REG_STAT, 32'hE);
		wr(`SBE_REG_OPEN, 32'hFF);
		// A second order while the first still runs must bounce, not cut it
		wr(`SBE_REG_CTRL, 32'h0);
		order(2'd0);
		check("busy refused", rd_val & 32'hF, 32'h6);
		wr(`SBE_REG_STAT, 32'hE);
		for (int k = 0; k < 4; k++) run_cfg(k);
		// Silent memory: the read must end in timeout, not hang
		mute <= 1'b1;
		order(2'd0);
		check("timeout", rd_val & 32'h9, 32'h8);
		check("model", 32'(viol), 32'h0);
		results();
	end

	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		results();
	end
endmodule
